// [hdl/mbmon_pkg.sv]
// constants of the board monitor register bank
package mbmon_pkg;
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int SELF_CHECK_NS = 10_000;
   localparam int MDC_HALF_NS   = 200;
   localparam int LED_HOLD_NS   = 50_000_000;
   localparam int BEACON_NS     = 1_000_000_000;
   localparam int SIM_CYCLES    = 64;

   function automatic int ns_to_cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int SELF_CHECK_CYCLES = ns_to_cyc_up(SELF_CHECK_NS);
   localparam int MDC_HALF_CYCLES   = ns_to_cyc_up(MDC_HALF_NS);
   localparam int LED_HOLD_CYCLES   = ns_to_cyc_up(LED_HOLD_NS);
   localparam int BEACON_CYCLES     = ns_to_cyc_up(BEACON_NS);

   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam logic [5:0] ADDR_FREQ_REF  = 6'h00;
   localparam logic [5:0] ADDR_LOOP_PHY  = 6'h01;
   localparam logic [5:0] ADDR_STAT_BASE = 6'h10;
   localparam int         NUM_STAT       = 28;
   localparam logic [7:0] CTRL_RESET     = 8'h00;

   localparam int FREQ_REF_BIT = 7;
   localparam int XLOOP_BIT    = 0;
   localparam int PLOOP_BIT    = 1;
   localparam int PDOWN_BIT    = 4;
   localparam int PRESET_BIT   = 6;
   localparam int LSYNC_BIT    = 5;

   localparam int STAT_SELF_LAST = 9;
   localparam int STAT_XCVR      = 10;
   localparam int STAT_ID_LO     = 11;
   localparam int STAT_ID_HI     = 12;
   localparam int STAT_MODULE    = 13;
   localparam int STAT_LANE      = 14;
   localparam int STAT_LSYNC     = 15;
   localparam int STAT_RXF_LO    = 17;
   localparam int STAT_RXF_HI    = 18;
   localparam int STAT_CRC_LO    = 19;
   localparam int STAT_CRC_HI    = 20;
   localparam int STAT_IPG       = 21;
   localparam int STAT_MAC_MSB   = 22;
   localparam int STAT_MAC_LSB   = 27;

   // -----------------------------------------------------------------
   // management frame and station address
   // -----------------------------------------------------------------
   localparam int         MD_PRE_BITS = 32;
   localparam int         MD_TA_START = 46;
   localparam int         MD_DATA_1ST = 48;
   localparam logic [5:0] MD_LAST     = 6'h3F;
   localparam logic [3:0] MD_ST_READ  = 4'h6;
   localparam int         MAC_MCAST   = 40;
   localparam int         MAC_LOCAL   = 41;
   localparam logic [1:0] TEST_NORMAL = 2'h0;
   localparam logic [1:0] TEST_LOOP   = 2'h1;
endpackage

// [hdl/mbmon_regs.sv]
// board monitor control and status register bank
module mbmon_regs
   import mbmon_pkg::*;
#(
   parameter bit SIMULATION      = 1'b0,
   parameter int LED_HOLD_CYC    = LED_HOLD_CYCLES,
   parameter int BEACON_CYC      = BEACON_CYCLES,
   parameter logic [4:0] PHY_ADDR = 5'h00,
   parameter logic [4:0] ID_REG   = 5'h02,
   parameter int UID_W            = 57
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   input  wire logic [5:0]       addr,
   input  wire logic [7:0]       wdata,
   input  wire logic             wr,
   input  wire logic             rd,
   output logic      [7:0]       rdata,
   output logic                  ext_ref_sel,
   input  wire logic [63:0]      mac_txd,
   input  wire logic [7:0]       mac_txc,
   input  wire logic [63:0]      phy_rxd,
   input  wire logic [7:0]       phy_rxc,
   output logic      [63:0]      mac_rxd,
   output logic      [7:0]       mac_rxc,
   output logic      [1:0]       phy_test_mode,
   output logic                  phy_power_down,
   output logic                  phy_soft_reset,
   output logic                  phy_config_change,
   output logic                  mdc,
   output logic                  mdio_out,
   output logic                  mdio_oe,
   input  wire logic             mdio_in,
   input  wire logic [79:0]      self_check_in,
   input  wire logic [5:0]       xcvr_status_in,
   input  wire logic [7:0]       module_status_in,
   input  wire logic [5:0]       phy_lane_status_in,
   input  wire logic             local_lane_sync_in,
   input  wire logic             rx_frame,
   input  wire logic             rx_crc_bad,
   input  wire logic [7:0]       rx_ipg_in,
   input  wire logic             tx_frame,
   input  wire logic [UID_W-1:0] device_uid_in,
   output logic                  rx_activity_indicator,
   output logic                  tx_activity_indicator,
   output logic                  beacon_request,
   output logic                  self_check_done
);
   // -----------------------------------------------------------------
   // timer lengths
   // -----------------------------------------------------------------
   localparam int SC_CYC  = SIMULATION ? SIM_CYCLES : SELF_CHECK_CYCLES;
   localparam int LED_CYC = SIMULATION ? SIM_CYCLES : LED_HOLD_CYC;
   localparam int BCN_CYC = SIMULATION ? SIM_CYCLES : BEACON_CYC;
   localparam logic [11:0] SC_LAST  = 12'(SC_CYC - 1);
   localparam logic [7:0]  MDC_LAST = 8'(MDC_HALF_CYCLES - 1);
   localparam logic [23:0] LED_LOAD = 24'(LED_CYC);
   localparam logic [27:0] BCN_LAST = 28'(BCN_CYC - 1);
   localparam logic [13:0] MD_HDR   = {MD_ST_READ, PHY_ADDR, ID_REG};

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {ST_CHECK, ST_MDIO, ST_RUN} mbm_state_type;

   typedef struct packed {
      mbm_state_type st;
      logic [11:0]   tmr;
      logic [7:0]    ctrl0;
      logic [7:0]    ctrl1;
      logic          cfg_chg;
      logic [79:0]   selfchk;
      logic [7:0]    xcvr;
      logic [7:0]    modst;
      logic [7:0]    lane;
      logic [7:0]    lsync;
      logic [15:0]   phy_id;
      logic [15:0]   rxcnt;
      logic [15:0]   crccnt;
      logic [7:0]    ipg;
      logic [47:0]   mac;
      logic [7:0]    rdata;
      logic [7:0]    md_div;
      logic [5:0]    md_bit;
      logic          mdc;
      logic          mdo;
      logic          mdoe;
      logic [23:0]   rx_led;
      logic [23:0]   tx_led;
      logic [27:0]   bcn;
      logic          bcn_pls;
      logic [63:0]   rxd;
      logic [7:0]    rxc;
   } mbm_regs_type;

   mbm_regs_type s_ff;
   mbm_regs_type nxt_s;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [1:0] md_drive(input logic [5:0] b);
      logic [1:0] r;
      r = 2'b00;
      if (int'(b) < MD_PRE_BITS) r = 2'b11;
      else if (int'(b) < MD_TA_START) r = {1'b1, MD_HDR[MD_TA_START-1-int'(b)]};
      return r;
   endfunction

   function automatic logic [7:0] stat_byte(input mbm_regs_type s,
                                            input int i);
      logic [7:0] r;
      r = 8'h00;
      if (i <= STAT_SELF_LAST) r = s.selfchk[8*(STAT_SELF_LAST-i) +: 8];
      else if (i >= STAT_MAC_MSB && i <= STAT_MAC_LSB)
         r = s.mac[8*(STAT_MAC_LSB-i) +: 8];
      else begin
         case (i)
            STAT_XCVR:   r = s.xcvr;
            STAT_ID_LO:  r = s.phy_id[7:0];
            STAT_ID_HI:  r = s.phy_id[15:8];
            STAT_MODULE: r = s.modst;
            STAT_LANE:   r = s.lane;
            STAT_LSYNC:  r = s.lsync;
            STAT_RXF_LO: r = s.rxcnt[7:0];
            STAT_RXF_HI: r = s.rxcnt[15:8];
            STAT_CRC_LO: r = s.crccnt[7:0];
            STAT_CRC_HI: r = s.crccnt[15:8];
            STAT_IPG:    r = s.ipg;
            default:     r = 8'h00;
         endcase
      end
      return r;
   endfunction

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      logic [5:0] sidx;
      logic [1:0] drv;
      sidx = 6'(addr - ADDR_STAT_BASE);
      drv = 2'b00;
      nxt_s = s_ff;
      nxt_s.cfg_chg = 1'b0;
      nxt_s.bcn_pls = 1'b0;
      nxt_s.rdata = 8'h00;

      // bus access, reads change only rdata and leave all other state alone
      if (wr && addr == ADDR_FREQ_REF) nxt_s.ctrl0 = wdata;
      if (wr && addr == ADDR_LOOP_PHY) begin
         nxt_s.ctrl1 = wdata;
         nxt_s.cfg_chg = 1'b1;
      end
      if (rd) begin
         if (addr == ADDR_FREQ_REF) nxt_s.rdata = s_ff.ctrl0;
         else if (addr == ADDR_LOOP_PHY) nxt_s.rdata = s_ff.ctrl1;
         else if (addr >= ADDR_STAT_BASE && int'(sidx) < NUM_STAT)
            nxt_s.rdata = stat_byte(s_ff, int'(sidx));
      end

      // live status sampling
      nxt_s.xcvr  = {2'b00, xcvr_status_in};
      nxt_s.modst = module_status_in;
      nxt_s.lane  = {2'b00, phy_lane_status_in};
      nxt_s.lsync = 8'h00;
      nxt_s.lsync[LSYNC_BIT] = local_lane_sync_in;

      // loopback mux on the receive words
      if (s_ff.ctrl1[XLOOP_BIT]) begin
         nxt_s.rxd = mac_txd;
         nxt_s.rxc = mac_txc;
      end else begin
         nxt_s.rxd = phy_rxd;
         nxt_s.rxc = phy_rxc;
      end

      // frame statistics, counters wrap
      if (rx_frame) begin
         nxt_s.rxcnt = 16'(s_ff.rxcnt + 16'h0001);
         nxt_s.ipg = rx_ipg_in;
      end
      if (rx_crc_bad)
         nxt_s.crccnt = 16'(s_ff.crccnt + 16'h0001);

      // activity stretchers
      if (rx_frame) nxt_s.rx_led = LED_LOAD;
      else if (s_ff.rx_led != '0) nxt_s.rx_led = 24'(s_ff.rx_led - 24'h1);
      if (tx_frame) nxt_s.tx_led = LED_LOAD;
      else if (s_ff.tx_led != '0) nxt_s.tx_led = 24'(s_ff.tx_led - 24'h1);

      // one second beacon tick
      if (s_ff.bcn == BCN_LAST) begin
         nxt_s.bcn = '0;
         nxt_s.bcn_pls = 1'b1;
      end else begin
         nxt_s.bcn = 28'(s_ff.bcn + 28'h1);
      end

      // power-up sequence: self check, then identifier read
      case (s_ff.st)
         ST_CHECK: begin
            nxt_s.tmr = 12'(s_ff.tmr + 12'h1);
            if (s_ff.tmr == SC_LAST) begin
               nxt_s.selfchk = self_check_in;
               nxt_s.mac = device_uid_in[47:0];
               nxt_s.mac[MAC_MCAST] = 1'b0;
               nxt_s.mac[MAC_LOCAL] = 1'b1;
               nxt_s.st = ST_MDIO;
               nxt_s.md_bit = '0;
               nxt_s.md_div = '0;
               nxt_s.mdc = 1'b0;
               drv = md_drive(6'h00);
               nxt_s.mdoe = drv[1];
               nxt_s.mdo = drv[0];
            end
         end
         ST_MDIO: begin
            if (s_ff.md_div == MDC_LAST) begin
               nxt_s.md_div = '0;
               nxt_s.mdc = ~s_ff.mdc;
               if (s_ff.mdc) begin
                  // falling edge: present the next bit
                  nxt_s.md_bit = 6'(s_ff.md_bit + 6'h1);
                  drv = md_drive(nxt_s.md_bit);
                  nxt_s.mdoe = drv[1];
                  nxt_s.mdo = drv[0];
               end else if (int'(s_ff.md_bit) >= MD_DATA_1ST) begin
                  // rising edge: capture the phy answer
                  nxt_s.phy_id = {s_ff.phy_id[14:0], mdio_in};
                  if (s_ff.md_bit == MD_LAST) begin
                     nxt_s.st = ST_RUN;
                     nxt_s.mdc = 1'b0;
                  end
               end
            end else begin
               nxt_s.md_div = 8'(s_ff.md_div + 8'h1);
            end
         end
         ST_RUN: nxt_s.mdoe = 1'b0;
         default: nxt_s.st = ST_CHECK;
      endcase
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_ff <= '0;
         s_ff.st <= ST_CHECK;
         s_ff.ctrl0 <= CTRL_RESET;
         s_ff.ctrl1 <= CTRL_RESET;
      end else if (ce) begin
         s_ff <= nxt_s;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign rdata = s_ff.rdata;
   assign ext_ref_sel = s_ff.ctrl0[FREQ_REF_BIT];
   assign mac_rxd = s_ff.rxd;
   assign mac_rxc = s_ff.rxc;
   assign phy_test_mode = s_ff.ctrl1[PLOOP_BIT] ? TEST_LOOP : TEST_NORMAL;
   assign phy_power_down = s_ff.ctrl1[PDOWN_BIT];
   assign phy_soft_reset = s_ff.ctrl1[PRESET_BIT];
   assign phy_config_change = s_ff.cfg_chg;
   assign mdc = s_ff.mdc;
   assign mdio_out = s_ff.mdo;
   assign mdio_oe = s_ff.mdoe;
   assign rx_activity_indicator = (s_ff.rx_led != '0);
   assign tx_activity_indicator = (s_ff.tx_led != '0);
   assign beacon_request = s_ff.bcn_pls;
   assign self_check_done = (s_ff.st != ST_CHECK);

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence wr_loop_seq;
      ce && wr && addr == ADDR_LOOP_PHY;
   endsequence

   sequence rd_xcvr_seq;
      ce [*2] ##0 rd && addr == ADDR_STAT_BASE + 6'(STAT_XCVR);
   endsequence

   a_freq_ref_out: assert property (
      ce && wr && addr == ADDR_FREQ_REF |=>
         ext_ref_sel == $past(wdata[FREQ_REF_BIT]))
      else $error("reference select not taken from write");

   a_xgmii_loop_path: assert property (
      ce && s_ff.ctrl1[XLOOP_BIT] |=> mac_rxd == $past(mac_txd))
      else $error("loopback words not returned");

   a_phy_loop_cmd: assert property (
      wr_loop_seq |=> phy_config_change &&
         phy_test_mode[0] == $past(wdata[PLOOP_BIT]))
      else $error("phy loopback command wrong");

   a_phy_pdown_reset: assert property (
      wr_loop_seq |=> phy_power_down == $past(wdata[PDOWN_BIT]) &&
         phy_soft_reset == $past(wdata[PRESET_BIT]))
      else $error("phy power down or reset wrong");

   a_self_check_latch: assert property (
      $rose(self_check_done) |-> s_ff.selfchk == $past(self_check_in))
      else $error("self check result not latched");

   a_xcvr_status_read: assert property (
      rd_xcvr_seq |=> rdata == {2'b00, $past(xcvr_status_in, 2)})
      else $error("transceiver status read wrong");

   a_mdio_turnaround: assert property (
      s_ff.st == ST_MDIO && int'(s_ff.md_bit) >= MD_TA_START |-> !mdio_oe)
      else $error("mdio driven during answer");

   a_rx_count_step: assert property (
      ce && rx_frame |=> s_ff.rxcnt == 16'($past(s_ff.rxcnt) + 16'h0001))
      else $error("received frame count step wrong");

   a_crc_count_step: assert property (
      ce && rx_crc_bad |=>
         s_ff.crccnt == 16'($past(s_ff.crccnt) + 16'h0001))
      else $error("bad crc count step wrong");

   a_rx_led_pulse: assert property (
      ce && rx_frame ##1 ce |-> rx_activity_indicator ##1
         rx_activity_indicator)
      else $error("rx activity not shown");

   a_lane_status_live: assert property (
      ce |=> s_ff.lane == {2'b00, $past(phy_lane_status_in)})
      else $error("phy lane status not sampled");

   a_lane_sync_flag: assert property (
      ce |=> s_ff.lsync[LSYNC_BIT] == $past(local_lane_sync_in))
      else $error("local lane sync flag not sampled");

   a_gap_capture: assert property (
      ce && rx_frame |=> s_ff.ipg == $past(rx_ipg_in))
      else $error("inter-packet gap not captured");

   a_station_addr: assert property (
      $rose(self_check_done) |-> s_ff.mac[MAC_LOCAL] &&
         !s_ff.mac[MAC_MCAST] && s_ff.mac[MAC_MCAST-1:0] ==
         $past(device_uid_in[MAC_MCAST-1:0]))
      else $error("station address not latched");

   a_beacon_single: assert property (
      ce && beacon_request |=> !beacon_request)
      else $error("beacon request longer than one cycle");

endmodule // mbmon_regs

// [sim/test_mbmon_regs.sv]
// self-checking bench of the board monitor register bank
module test_mbmon_regs
   import mbmon_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int         LED_C    = 64;
   localparam int         BCN_C    = 64;
   localparam logic [4:0] TB_PADDR = 5'h05;
   localparam logic [4:0] TB_IDREG = 5'h03;
   localparam logic [15:0] PHY_ID  = 16'h5a3c; // arbitrary id value

   logic        clk, rst_n, ce, wr, rd, mdc, mdio_out, mdio_oe, mdio_in;
   logic [5:0]  addr;
   logic [7:0]  wdata, rdata, mac_txc, phy_rxc, mac_rxc, module_status_in;
   logic [63:0] mac_txd, phy_rxd, mac_rxd;
   logic [1:0]  phy_test_mode;
   logic        ext_ref_sel, phy_power_down, phy_soft_reset;
   logic        phy_config_change, local_lane_sync_in, self_check_done;
   logic [79:0] self_check_in, sc_exp;
   logic [5:0]  xcvr_status_in, phy_lane_status_in;
   logic        rx_frame, rx_crc_bad, tx_frame, beacon_request;
   logic [7:0]  rx_ipg_in, ipg_exp;
   logic [56:0] device_uid_in, uid_exp;
   logic        rx_activity_indicator, tx_activity_indicator;
   logic [15:0] rxn_exp, crcn_exp;
   logic [6:0]  fcnt;
   logic [45:0] hdr;
   logic [31:0] seed;
   int          oe_bad, miscompares, cmp_count;

   mbmon_regs #(.SIMULATION(1'b1), .LED_HOLD_CYC(LED_C), .BEACON_CYC(BCN_C),
      .PHY_ADDR(TB_PADDR), .ID_REG(TB_IDREG)) mbmon_regs_i (
      .clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .ext_ref_sel(ext_ref_sel),
      .mac_txd(mac_txd), .mac_txc(mac_txc), .phy_rxd(phy_rxd),
      .phy_rxc(phy_rxc), .mac_rxd(mac_rxd), .mac_rxc(mac_rxc),
      .phy_test_mode(phy_test_mode), .phy_power_down(phy_power_down),
      .phy_soft_reset(phy_soft_reset), .phy_config_change(phy_config_change),
      .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdio_in(mdio_in),
      .self_check_in(self_check_in), .xcvr_status_in(xcvr_status_in),
      .module_status_in(module_status_in),
      .phy_lane_status_in(phy_lane_status_in),
      .local_lane_sync_in(local_lane_sync_in), .rx_frame(rx_frame),
      .rx_crc_bad(rx_crc_bad), .rx_ipg_in(rx_ipg_in), .tx_frame(tx_frame),
      .device_uid_in(device_uid_in),
      .rx_activity_indicator(rx_activity_indicator),
      .tx_activity_indicator(tx_activity_indicator),
      .beacon_request(beacon_request), .self_check_done(self_check_done));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // -----------------------------------------------------------------
   // management responder: data bit i valid at mdc rising i
   // -----------------------------------------------------------------
   always @(negedge mdc or negedge rst_n) begin
      if (!rst_n) fcnt <= 7'h00;
      else fcnt <= fcnt + 7'h01;
   end
   assign mdio_in = (fcnt >= 48 && fcnt < 64) ? PHY_ID[7'd63 - fcnt]
                                              : fcnt[0];
   always @(posedge mdc) begin
      if (fcnt < 46) hdr <= {hdr[44:0], mdio_out};
      if (fcnt >= 48 && fcnt < 64 && mdio_oe !== 1'b0) oe_bad++;
   end

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [7:0] exp_stat(input int n);
      logic [47:0] m;
      m = uid_exp[47:0];
      m[MAC_MCAST] = 1'b0;
      m[MAC_LOCAL] = 1'b1;
      if (n <= STAT_SELF_LAST) return sc_exp[8*(STAT_SELF_LAST-n)+:8];
      if (n >= STAT_MAC_MSB) return m[8*(STAT_MAC_LSB-n)+:8];
      case (n)
         STAT_XCVR:   return {2'b00, xcvr_status_in};
         STAT_ID_LO:  return PHY_ID[7:0];
         STAT_ID_HI:  return PHY_ID[15:8];
         STAT_MODULE: return module_status_in;
         STAT_LANE:   return {2'b00, phy_lane_status_in};
         STAT_LSYNC:  return {2'b00, local_lane_sync_in, 5'h00};
         STAT_RXF_LO: return rxn_exp[7:0];
         STAT_RXF_HI: return rxn_exp[15:8];
         STAT_CRC_LO: return crcn_exp[7:0];
         STAT_CRC_HI: return crcn_exp[15:8];
         STAT_IPG:    return ipg_exp;
         default:     return 8'h00;
      endcase
   endfunction

   task automatic chk_v(input string nm, input logic [63:0] e, g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_b(input string nm, input logic e, g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic wait_on(input int w, input int lim);
      for (int k = 0; k < lim; k++) begin
         @(negedge clk);
         if ((w == 0 && self_check_done === 1'b1) || (w == 1 && fcnt >= 63)
             || (w == 2 && beacon_request === 1'b1)) return;
      end
      miscompares++;
      $display("unexpected timeout on wait %0d", w);
      close_out();
   endtask

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      logic [7:0]  v, v2, d;
      logic [63:0] pt;
      logic [7:0]  pc;
      logic [5:0]  unm [4];
      int          kf, kc, cnt;
      seed = 32'h0000_0030;
      {rst_n, ce, wr, rd, rx_frame, rx_crc_bad, tx_frame} = 7'h20;
      {addr, wdata, mac_txd, mac_txc, phy_rxd, phy_rxc} = '0;
      {self_check_in, xcvr_status_in, module_status_in} = '0;
      {phy_lane_status_in, local_lane_sync_in, rx_ipg_in} = '0;
      {device_uid_in, ipg_exp, rxn_exp, crcn_exp, hdr} = '0;
      sc_exp = 80'({rnd(), rnd(), rnd()});
      uid_exp = 57'({rnd(), rnd()});
      self_check_in = sc_exp;
      device_uid_in = uid_exp;
      {oe_bad, miscompares, cmp_count} = '0;
      repeat (10) @(posedge clk);
      chk_v("reset outputs", 64'h0, {rdata, ext_ref_sel, phy_test_mode,
         phy_power_down, phy_soft_reset, phy_config_change, beacon_request});
      rst_n <= 1'b1;
      rd_reg(ADDR_LOOP_PHY, d);
      chk_v("control reset", CTRL_RESET, d);
      for (int i = 0; i < 8; i++) begin
         v = (i == 0) ? 8'hff : 8'(rnd());
         v2 = 8'(rnd());
         wr_reg(ADDR_LOOP_PHY, v);
         @(negedge clk);
         chk_b("config pulse", 1'b1, phy_config_change);
         chk_v("test mode", {1'b0, v[PLOOP_BIT]}, phy_test_mode);
         chk_b("power down", v[PDOWN_BIT], phy_power_down);
         chk_b("soft reset", v[PRESET_BIT], phy_soft_reset);
         @(negedge clk);
         chk_b("config pulse end", 1'b0, phy_config_change);
         rd_reg(ADDR_LOOP_PHY, d);
         chk_v("loop control", v, d);
         wr_reg(ADDR_FREQ_REF, v2);
         @(negedge clk);
         chk_b("reference select", v2[FREQ_REF_BIT], ext_ref_sel);
         @(posedge clk);
         ce <= 1'b0;
         wr_reg(ADDR_FREQ_REF, ~v2);
         ce <= 1'b1;
         rd_reg(ADDR_FREQ_REF, d);
         chk_v("reference control", v2, d);
      end
      wr_reg(ADDR_FREQ_REF, 8'h00);
      $display("test control finished");
      for (int m = 0; m < 2; m++) begin
         wr_reg(ADDR_LOOP_PHY, {7'h00, m[0]});
         for (int j = 0; j < 24; j++) begin
            @(negedge clk);
            if (j > 1) begin
               chk_v("rx words", pt, mac_rxd);
               chk_v("rx control", {56'h0, pc}, {56'h0, mac_rxc});
            end
            pt = m ? mac_txd : phy_rxd;
            pc = m ? mac_txc : phy_rxc;
            @(posedge clk);
            mac_txd <= {rnd(), rnd()};
            phy_rxd <= {rnd(), rnd()};
            mac_txc <= 8'(rnd());
            phy_rxc <= 8'(rnd());
         end
      end
      wr_reg(ADDR_LOOP_PHY, 8'h00);
      $display("test loopback finished");
      wait_on(0, 3000);
      wait_on(1, 8000);
      repeat (200) @(posedge clk);
      chk_v("mdio header", {32'hffff_ffff, MD_ST_READ, TB_PADDR, TB_IDREG},
         hdr);
      chk_v("mdio drive in data", 64'h0, oe_bad);
      $display("test identifier finished");
      kf = 65536 + (rnd() % 16) + 1;
      kc = (rnd() % 5) + 1;
      for (int j = 0; j < kf; j++) begin
         v = 8'd5 + 8'(rnd() % 251);
         @(posedge clk);
         rx_frame <= 1'b1;
         rx_crc_bad <= (j < kc);
         rx_ipg_in <= v;
         ipg_exp = v;
      end
      @(posedge clk);
      rx_frame <= 1'b0;
      rx_crc_bad <= 1'b0;
      rxn_exp = kf[15:0];
      crcn_exp = kc[15:0];
      @(negedge clk);
      chk_b("rx led", 1'b1, rx_activity_indicator);
      chk_b("tx led idle", 1'b0, tx_activity_indicator);
      repeat (LED_C + 16) @(posedge clk);
      chk_b("rx led off", 1'b0, rx_activity_indicator);
      tx_frame <= 1'b1;
      @(posedge clk);
      tx_frame <= 1'b0;
      @(negedge clk);
      chk_b("tx led", 1'b1, tx_activity_indicator);
      chk_b("rx led idle", 1'b0, rx_activity_indicator);
      repeat (LED_C + 16) @(posedge clk);
      chk_b("tx led off", 1'b0, tx_activity_indicator);
      $display("test counters finished");
      @(posedge clk);
      self_check_in <= 80'({rnd(), rnd(), rnd()});
      xcvr_status_in <= 6'(rnd());
      module_status_in <= 8'(rnd());
      phy_lane_status_in <= 6'(rnd());
      local_lane_sync_in <= 1'b1;
      device_uid_in <= 57'({rnd(), rnd()});
      wr_reg(ADDR_STAT_BASE + 6'(STAT_XCVR), 8'hff);
      repeat (2) @(posedge clk);
      for (int p = 0; p < 2; p++)
         for (int n = 0; n < NUM_STAT; n++) begin
            rd_reg(ADDR_STAT_BASE + 6'(n), d);
            chk_v($sformatf("status %0d", n), exp_stat(n), d);
         end
      unm = '{6'h02, 6'h0f, 6'h2c, 6'h3f};
      foreach (unm[i]) begin
         rd_reg(unm[i], d);
         chk_v("unmapped", 64'h0, d);
      end
      $display("test status finished");
      wait_on(2, 200);
      cnt = 1;
      @(negedge clk);
      while (beacon_request !== 1'b1 && cnt < 200) begin
         cnt++;
         @(negedge clk);
      end
      chk_v("beacon spacing", BCN_C, cnt);
      $display("test beacon finished");
      close_out();
   end
endmodule // test_mbmon_regs
